// [autrf_top.sv]
`timescale 1ns/1ns
`default_nettype none
module autrf_top
  import autrf_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic receive_pin,
  output logic tx_out,
  output logic tx_out_en_n,
  output logic tx_irq
);
  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] baud_control_reg, receive_status_control_reg;
  logic [7:0] baud_divisor_low_reg, baud_divisor_high_reg;
  logic [7:0] transmit_holding_reg, transmit_status_control_reg, irq_control_reg;
  logic hold_full_reg;
  logic [31:0] prdata_reg;
  autrf_state_type tx_state_reg, rx_state_reg;
  logic [8:0] tx_shifter_reg;
  logic [3:0] tx_tick_reg, tx_bit_reg;
  logic tx_out_reg;
  logic [15:0] baud_cnt_reg;
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic [8:0] rx_shifter_reg;
  logic [3:0] rx_tick_reg, rx_bit_reg;
  logic [8:0] fifo_mem [FIFO_DEPTH];
  logic [1:0] fifo_cnt_reg;
  logic fifo_wp_reg, fifo_rp_reg;

  // control decode
  wire port_enable = receive_status_control_reg[RSC_PORT_ENABLE];
  wire sync_sel = transmit_status_control_reg[TSC_SYNC];
  wire transmitter_enable = transmit_status_control_reg[TSC_TX_ENABLE];
  wire receive_enable = receive_status_control_reg[RSC_RECEIVE_ENABLE];
  wire tx_nine_bit_select = transmit_status_control_reg[TSC_NINE_BIT];
  wire rx_nine_bit = receive_status_control_reg[RSC_NINE_BIT];
  wire addr_detect = receive_status_control_reg[RSC_ADDRESS_DETECT];
  wire polarity_select = baud_control_reg[BC_POLARITY];
  wire tx_active = port_enable & transmitter_enable & ~sync_sel;
  wire rx_active = receive_enable & ~sync_sel & port_enable;

  // bus strobes
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr = access_ph & pwrite & clk_en & pstrb[0];
  wire rd = access_ph & ~pwrite & clk_en;
  wire mapped = hit(paddr, OFF_BAUD_CONTROL) | hit(paddr, OFF_RECEIVE_STATUS_CONTROL)
    | hit(paddr, OFF_BAUD_DIVISOR_LOW) | hit(paddr, OFF_BAUD_DIVISOR_HIGH)
    | hit(paddr, OFF_TRANSMIT_HOLDING) | hit(paddr, OFF_TRANSMIT_STATUS_CONTROL)
    | hit(paddr, OFF_RECEIVE_DATA) | hit(paddr, OFF_IRQ_CONTROL);
  wire hold_wr = wr & hit(paddr, OFF_TRANSMIT_HOLDING);
  wire rx_pop = rd & hit(paddr, OFF_RECEIVE_DATA) & (fifo_cnt_reg != 2'h0);

  // status flags
  wire tx_buffer_empty_flag = tx_active & ~hold_full_reg;
  wire shifter_empty_flag = (tx_state_reg == ST_IDLE);
  wire [8:0] fifo_top = (fifo_cnt_reg != 2'h0) ? fifo_mem[fifo_rp_reg] : 9'h000; // empty reads 0
  wire global_irq_enable = irq_control_reg[IC_GLOBAL];
  wire peripheral_irq_enable = irq_control_reg[IC_PERIPHERAL];
  wire tx_empty_irq_enable = irq_control_reg[IC_TX_EMPTY];

  // shared oversample tick
  wire [15:0] divisor = baud_control_reg[BC_WIDE_DIVISOR]
    ? {baud_divisor_high_reg, baud_divisor_low_reg} : {8'h00, baud_divisor_low_reg};
  wire tick16 = clk_en & port_enable & (baud_cnt_reg == divisor);

  // transmit load and bit count
  wire tx_load = clk_en & tx_active & hold_full_reg & (tx_state_reg == ST_IDLE);
  wire [3:0] tx_nbits = tx_nine_bit_select ? DATA_BITS_9 : DATA_BITS_8;
  wire tx_bit_end = tick16 & (tx_tick_reg == TICKS_PER_BIT_M1);
  wire tx_line = (tx_state_reg == ST_START) ? 1'b0
    : (tx_state_reg == ST_DATA) ? tx_shifter_reg[0] : 1'b1;

  // receive sampling
  wire rx_fall = rx_s3_reg & ~rx_s2_reg;
  wire [3:0] rx_nbits = rx_nine_bit ? DATA_BITS_9 : DATA_BITS_8;
  wire rx_bit_end = tick16 & (rx_tick_reg == TICKS_PER_BIT_M1);
  wire rx_half = tick16 & (rx_tick_reg == TICKS_HALF_BIT_M1);
  wire [8:0] rx_char = rx_nine_bit ? rx_shifter_reg : {1'b0, rx_shifter_reg[8:1]};
  wire rx_keep = ~(addr_detect & rx_nine_bit & ~rx_char[8]);
  wire rx_done = rx_active & (rx_state_reg == ST_STOP) & rx_bit_end;
  wire rx_push = rx_done & rx_keep & (fifo_cnt_reg != 2'(FIFO_DEPTH));

  // read mux, unimplemented bits zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr, OFF_BAUD_CONTROL)) begin
      rd_byte = baud_control_reg & 8'h18;
    end else if (hit(paddr, OFF_RECEIVE_STATUS_CONTROL)) begin
      rd_byte = (receive_status_control_reg & 8'hD8) | {7'h00, fifo_top[8]};
    end else if (hit(paddr, OFF_BAUD_DIVISOR_LOW)) begin
      rd_byte = baud_divisor_low_reg;
    end else if (hit(paddr, OFF_BAUD_DIVISOR_HIGH)) begin
      rd_byte = baud_divisor_high_reg;
    end else if (hit(paddr, OFF_TRANSMIT_STATUS_CONTROL)) begin
      rd_byte = (transmit_status_control_reg & 8'h75)
        | {6'h00, shifter_empty_flag, 1'b0};
    end else if (hit(paddr, OFF_RECEIVE_DATA)) begin
      rd_byte = fifo_top[7:0];
    end else if (hit(paddr, OFF_IRQ_CONTROL)) begin
      rd_byte = {irq_control_reg[7:3] & 5'h00, irq_control_reg[2:0]};
    end
  end

  // apb answer: one access cycle, data latched at setup
  assign pready = penable;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en && setup_ph) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // software registers; status bits are not stored from writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_control_reg <= RST_CONTROL;
      receive_status_control_reg <= RST_CONTROL;
      baud_divisor_low_reg <= RST_DIVISOR;
      baud_divisor_high_reg <= RST_DIVISOR;
      transmit_status_control_reg <= RST_CONTROL;
      irq_control_reg <= RST_CONTROL;
    end else if (wr) begin
      if (hit(paddr, OFF_BAUD_CONTROL)) begin
        baud_control_reg <= pwdata[7:0] & 8'h18;
      end
      if (hit(paddr, OFF_RECEIVE_STATUS_CONTROL)) begin
        receive_status_control_reg <= pwdata[7:0] & 8'hD8;
      end
      if (hit(paddr, OFF_BAUD_DIVISOR_LOW)) begin
        baud_divisor_low_reg <= pwdata[7:0];
      end
      if (hit(paddr, OFF_BAUD_DIVISOR_HIGH)) begin
        baud_divisor_high_reg <= pwdata[7:0];
      end
      if (hit(paddr, OFF_TRANSMIT_STATUS_CONTROL)) begin
        transmit_status_control_reg <= pwdata[7:0] & 8'h75;
      end
      if (hit(paddr, OFF_IRQ_CONTROL)) begin
        irq_control_reg <= pwdata[7:0] & 8'h07;
      end
    end
  end

  // transmit holding register and its full flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_holding_reg <= 8'h00;
      hold_full_reg <= 1'b0;
    end else if (clk_en) begin
      if (hold_wr) begin
        transmit_holding_reg <= pwdata[7:0];
      end
      if (!tx_active) begin
        hold_full_reg <= 1'b0;
      end else if (hold_wr) begin
        hold_full_reg <= 1'b1;
      end else if (tx_load) begin
        hold_full_reg <= 1'b0;
      end
    end
  end

  // baud counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!port_enable || tick16) begin
        baud_cnt_reg <= 16'h0000;
      end else begin
        baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      end
    end
  end

  // transmit state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= ST_IDLE;
      tx_shifter_reg <= 9'h000;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
    end else if (clk_en) begin
      if (!tx_active) begin
        tx_state_reg <= ST_IDLE;
        tx_tick_reg <= 4'h0;
      end else begin
        if (tick16) begin
          tx_tick_reg <= tx_tick_reg + 4'h1;
        end
        case (tx_state_reg)
          ST_IDLE: begin
            if (tx_load) begin
              tx_shifter_reg <= {transmit_status_control_reg[TSC_NINTH_BIT],
                transmit_holding_reg};
              tx_state_reg <= ST_START;
              tx_tick_reg <= 4'h0;
            end
          end
          ST_START: begin
            if (tx_bit_end) begin
              tx_state_reg <= ST_DATA;
              tx_bit_reg <= 4'h0;
            end
          end
          ST_DATA: begin
            if (tx_bit_end) begin
              tx_shifter_reg <= {1'b0, tx_shifter_reg[8:1]};
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_bit_reg == tx_nbits - 4'h1) begin
                tx_state_reg <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            if (tx_bit_end) begin
              tx_state_reg <= ST_IDLE;
            end
          end
          default: tx_state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // output pin, driven while port and transmitter are enabled in async mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_reg <= 1'b1;
    end else if (clk_en) begin
      tx_out_reg <= tx_line ^ polarity_select;
    end
  end
  assign tx_out = tx_out_reg;
  assign tx_out_en_n = ~tx_active;
  assign tx_irq = tx_buffer_empty_flag & tx_empty_irq_enable
    & global_irq_enable & peripheral_irq_enable;

  // receive pin synchroniser and edge stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
    end else if (clk_en) begin
      rx_s1_reg <= receive_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end

  // receive state machine at sixteen ticks per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= ST_IDLE;
      rx_shifter_reg <= 9'h000;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
    end else if (clk_en) begin
      if (!rx_active) begin
        rx_state_reg <= ST_IDLE;
        rx_tick_reg <= 4'h0;
      end else begin
        if (tick16) begin
          rx_tick_reg <= rx_tick_reg + 4'h1;
        end
        case (rx_state_reg)
          ST_IDLE: begin
            if (rx_fall) begin
              rx_state_reg <= ST_START;
              rx_tick_reg <= 4'h0;
            end
          end
          ST_START: begin
            if (rx_half) begin
              rx_tick_reg <= 4'h0;
              rx_bit_reg <= 4'h0;
              rx_state_reg <= rx_s2_reg ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_bit_end) begin
              rx_shifter_reg <= {rx_s2_reg, rx_shifter_reg[8:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == rx_nbits - 4'h1) begin
                rx_state_reg <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            if (rx_bit_end) begin
              rx_state_reg <= ST_IDLE;
            end
          end
          default: rx_state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // two-entry receive buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_cnt_reg <= 2'h0;
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
    end else if (clk_en) begin
      if (!port_enable) begin
        fifo_cnt_reg <= 2'h0;
        fifo_wp_reg <= 1'b0;
        fifo_rp_reg <= 1'b0;
      end else begin
        if (rx_push) begin
          fifo_wp_reg <= ~fifo_wp_reg;
        end
        if (rx_pop) begin
          fifo_rp_reg <= ~fifo_rp_reg;
        end
        fifo_cnt_reg <= fifo_cnt_reg + {1'b0, rx_push} - {1'b0, rx_pop};
      end
    end
  end
  always_ff @(posedge pclk) begin
    if (clk_en && port_enable && rx_push) begin
      fifo_mem[fifo_wp_reg] <= rx_char;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load_idle;
    clk_en && hold_wr && tx_active && !hold_full_reg && tx_state_reg == ST_IDLE;
  endsequence
  sequence s_two_live;
    clk_en ##1 clk_en && tx_active;
  endsequence

  a_flag_after_write: assert property (
    s_load_idle ##0 s_two_live |=> tx_buffer_empty_flag
  ) else $error("empty flag not valid two cycles after write");
  a_enable_sets_flag: assert property (
    $rose(tx_active) && !hold_full_reg |-> tx_buffer_empty_flag
  ) else $error("enable did not set empty flag");
  a_shifter_busy: assert property (
    tx_load |=> !shifter_empty_flag ##0 (tx_state_reg == ST_START)
  ) else $error("shifter empty flag stayed set after load");
  a_nine_bit_only: assert property (
    tx_state_reg == ST_DATA && tx_bit_reg == 4'h8 |-> tx_nine_bit_select
  ) else $error("ninth bit sent in eight bit mode");
  a_irq_gating: assert property (
    tx_buffer_empty_flag && !tx_empty_irq_enable |-> !tx_irq
  ) else $error("request not gated by enable");
  a_irq_immediate: assert property (
    tx_buffer_empty_flag && tx_empty_irq_enable && global_irq_enable
      && peripheral_irq_enable |-> tx_irq
  ) else $error("enabled request missing");
  a_idle_level: assert property (
    clk_en && tx_state_reg == ST_IDLE && !tx_load && $stable(polarity_select)
      |=> tx_out == !$past(polarity_select)
  ) else $error("idle line level wrong");
  a_start_level: assert property (
    clk_en && tx_state_reg == ST_START |=> tx_out == $past(polarity_select)
  ) else $error("start bit level wrong");
  a_fifo_depth: assert property (
    fifo_cnt_reg <= 2'(FIFO_DEPTH)
  ) else $error("receive buffer above two entries");
  a_rx_gated: assert property (
    clk_en && !rx_active |=> rx_state_reg == ST_IDLE && !rx_push
  ) else $error("receiver ran while disabled");
  a_port_off: assert property (
    clk_en && !port_enable |=> fifo_cnt_reg == 2'h0 && tx_state_reg == ST_IDLE
  ) else $error("port disable did not reset state");
endmodule
`default_nettype wire

// [autrf_pkg.sv]
// Functional notes
// - empty flag set while enabled, holding empty
// - empty flag valid second cycle after write
// - empty flag is read-only; here no register bit reads it, it only drives tx_irq
// - flag ignores interrupt enable; only request gated
// - shifter-empty flag clears on load until shifted
// - shifter-empty flag drives no interrupt
// - nine-bit select sends ninth bit as msb
// - ninth bit first; all nine bits load together
// - ninth bit one marks an address character
// - transmit enable sets the empty flag at once
// - enabled interrupt fires at once when flag set
// - holding write starts transmission when enabled
// - receiver oversamples at sixteen times baud
// - finished character moves into two-entry buffer
// - two characters buffered while third assembles
// - received data only via receive data register
// - reception needs receive enable, async, port enable
// - unimplemented control bits read as zero
// - start space, data lsb first, stop mark, idle mark
// - queued character moves one cycle after stop bit
// - polarity select inverts transmit output
// - start bit rechecked at half bit, else abandoned
package autrf_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL = 8'h04;
  localparam logic [7:0] OFF_BAUD_DIVISOR_LOW = 8'h08;
  localparam logic [7:0] OFF_BAUD_DIVISOR_HIGH = 8'h0C;
  localparam logic [7:0] OFF_TRANSMIT_HOLDING = 8'h10;
  localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h14;
  localparam logic [7:0] OFF_RECEIVE_DATA = 8'h18;
  localparam logic [7:0] OFF_IRQ_CONTROL = 8'h1C;
  // transmit status/control fields
  localparam int TSC_NINE_BIT = 6;
  localparam int TSC_TX_ENABLE = 5;
  localparam int TSC_SYNC = 4;
  localparam int TSC_HIGH_SPEED = 2;
  localparam int TSC_SHIFTER_EMPTY = 1;
  localparam int TSC_NINTH_BIT = 0;
  // receive status/control fields
  localparam int RSC_PORT_ENABLE = 7;
  localparam int RSC_NINE_BIT = 6;
  localparam int RSC_RECEIVE_ENABLE = 4;
  localparam int RSC_ADDRESS_DETECT = 3;
  localparam int RSC_NINTH_BIT = 0;
  // baud control fields
  localparam int BC_POLARITY = 4;
  localparam int BC_WIDE_DIVISOR = 3;
  // interrupt control fields
  localparam int IC_GLOBAL = 2;
  localparam int IC_PERIPHERAL = 1;
  localparam int IC_TX_EMPTY = 0;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  // timing counts in oversample ticks, data bit counts, buffer depth
  localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;
  localparam logic [3:0] TICKS_HALF_BIT_M1 = 4'h7;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam int RX_FIFO_DEPTH = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} autrf_state_type;
endpackage

// [autrf_peer.sv]
`timescale 1ns/1ns
`default_nettype none
// remote serial peer: decodes frames from the transmit line, sends frames on the receive line
module autrf_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic pclk,
  input wire logic line_in,
  input wire logic inv,
  input wire logic nine,
  output logic line_out
);
  logic [9:0] rx_q[$];
  logic [9:0] v;
  // frame decoder: start checked at mid bit, data lsb first, stop sampled last
  always begin
    @(posedge pclk);
    if ((line_in ^ inv) === 1'b0) begin
      repeat (BIT_CLKS / 2) @(posedge pclk);
      if ((line_in ^ inv) === 1'b0) begin
        v = 10'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT_CLKS) @(posedge pclk);
          v[i] = line_in ^ inv;
        end
        repeat (BIT_CLKS) @(posedge pclk);
        v[9] = line_in ^ inv;
        rx_q.push_back(v);
      end
    end
  end
  initial line_out = 1'b1; // idle at mark
  // one frame: start at space, data lsb first, one stop at mark
  task automatic send(input logic [8:0] d, input int n);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
    line_out <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge pclk);
  endtask
  // short low pulse, well under half a bit
  task automatic glitch();
    line_out <= 1'b0;
    repeat (4) @(posedge pclk);
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// [autrf_top_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module autrf_top_bench;
  import autrf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_out, tx_out_en_n, tx_irq, rx_line;
  logic inv = 1'b0;
  logic nine = 1'b0;
  logic [31:0] q;
  logic e;
  int err_count = 0;
  int cmp_count = 0;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  autrf_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .receive_pin(rx_line),
    .tx_out(tx_out), .tx_out_en_n(tx_out_en_n), .tx_irq(tx_irq));
  // divisor 1 gives a tick every 2 clocks, 32 clocks a bit
  autrf_peer #(.BIT_CLKS(32)) u_peer (.pclk(pclk), .line_in(tx_out), .inv(inv),
    .nine(nine), .line_out(rx_line));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, then access until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      stop_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wait_rx(input int cnt);
    int n;
    n = 0;
    while (u_peer.rx_q.size() < cnt && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  initial begin
    logic [7:0] offs[6];
    offs = '{OFF_BAUD_CONTROL, OFF_RECEIVE_STATUS_CONTROL, OFF_BAUD_DIVISOR_LOW,
      OFF_BAUD_DIVISOR_HIGH, OFF_TRANSMIT_HOLDING, OFF_IRQ_CONTROL};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped address
    foreach (offs[i]) begin
      rd(offs[i]);
      check(q, 32'h0);
    end
    rd(8'h20);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    done("reset");
    // configure: divisor, interrupts, port, transmitter last
    wr(OFF_BAUD_DIVISOR_LOW, 32'hFFFF_FF01);
    rd(OFF_BAUD_DIVISOR_LOW);
    check(q, 32'h0000_0001);
    wr(OFF_IRQ_CONTROL, 32'h7);
    wr(OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    wr(OFF_TRANSMIT_STATUS_CONTROL, 32'h20);
    tick(1);
    check({31'h0, tx_irq}, 32'h1);
    check({31'h0, tx_out_en_n}, 32'h0);
    rd(OFF_TRANSMIT_STATUS_CONTROL);
    check(q, 32'h22);
    wr(OFF_IRQ_CONTROL, 32'h3);
    tick(1);
    check({31'h0, tx_irq}, 32'h0);
    wr(OFF_IRQ_CONTROL, 32'h7);
    tick(1);
    check({31'h0, tx_irq}, 32'h1);
    done("enable");
    // two characters back to back: second waits in holding
    wr(OFF_TRANSMIT_HOLDING, 32'hA5);
    tick(3);
    check({31'h0, tx_irq}, 32'h1);
    wr(OFF_TRANSMIT_HOLDING, 32'h3C);
    tick(2);
    check({31'h0, tx_irq}, 32'h0);
    rd(OFF_TRANSMIT_STATUS_CONTROL);
    check(q, 32'h20);
    wait_rx(2);
    check({22'h0, u_peer.rx_q[0]}, 32'h2A5);
    check({22'h0, u_peer.rx_q[1]}, 32'h23C);
    tick(40);
    rd(OFF_TRANSMIT_STATUS_CONTROL);
    check(q, 32'h22);
    check({31'h0, tx_irq}, 32'h1);
    done("transmit");
    // nine-bit character with ninth bit set
    u_peer.rx_q.delete();
    nine = 1'b1;
    wr(OFF_TRANSMIT_STATUS_CONTROL, 32'h61);
    wr(OFF_IRQ_CONTROL, 32'h3);
    wr(OFF_TRANSMIT_HOLDING, 32'h55);
    wait_rx(1);
    check({22'h0, u_peer.rx_q[0]}, 32'h355);
    check({31'h0, tx_irq}, 32'h0);
    tick(40);
    wr(OFF_IRQ_CONTROL, 32'h7);
    nine = 1'b0;
    wr(OFF_TRANSMIT_STATUS_CONTROL, 32'h20);
    done("nine bit");
    // inverted output
    // peer polarity flips on the same edge as the line, so no false start is seen
    wr(OFF_BAUD_CONTROL, 32'h10);
    @(posedge pclk);
    inv <= 1'b1;
    tick(1);
    check({31'h0, tx_out}, 32'h0);
    tick(40);
    u_peer.rx_q.delete();
    wr(OFF_TRANSMIT_HOLDING, 32'h5A);
    wait_rx(1);
    check({22'h0, u_peer.rx_q[0]}, 32'h25A);
    tick(40);
    wr(OFF_BAUD_CONTROL, 32'h0);
    @(posedge pclk);
    inv <= 1'b0;
    tick(1);
    done("polarity");
    // receiver off drops, then three characters, two kept in order
    u_peer.send(9'h066, 8);
    wr(OFF_RECEIVE_STATUS_CONTROL, 32'h90);
    u_peer.send(9'h011, 8);
    u_peer.send(9'h022, 8);
    u_peer.send(9'h033, 8);
    rd(OFF_RECEIVE_DATA);
    check(q, 32'h11);
    rd(OFF_RECEIVE_DATA);
    check(q, 32'h22);
    u_peer.glitch();
    u_peer.send(9'h044, 8);
    rd(OFF_RECEIVE_DATA);
    check(q, 32'h44);
    done("receive");
    // address detect keeps only ninth-bit-set characters
    wr(OFF_RECEIVE_STATUS_CONTROL, 32'hD8);
    u_peer.send(9'h0AA, 9);
    u_peer.send(9'h1BB, 9);
    rd(OFF_RECEIVE_STATUS_CONTROL);
    check(q, 32'hD9);
    rd(OFF_RECEIVE_DATA);
    check(q, 32'hBB);
    done("address");
    // port disable mid transfer returns to idle
    wr(OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    wr(OFF_TRANSMIT_HOLDING, 32'h11);
    tick(3);
    wr(OFF_TRANSMIT_HOLDING, 32'h22);
    wr(OFF_RECEIVE_STATUS_CONTROL, 32'h00);
    tick(2);
    check({30'h0, tx_out_en_n, tx_out}, 32'h3);
    wr(OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    tick(2);
    check({31'h0, tx_irq}, 32'h1);
    rd(OFF_TRANSMIT_STATUS_CONTROL);
    check(q, 32'h22);
    done("port off");
    stop_test();
  end
endmodule
`default_nettype wire
